/* File: verilog/flash_cmd_pkg.sv */
package flash_cmd_pkg;

    // Serial opcodes handled by the command interpreter.
    localparam logic [7:0] OP_ENTER_FOUR_LINE = 8'h38;
    localparam logic [7:0] OP_EXIT_FOUR_LINE  = 8'hFF;
    localparam logic [7:0] OP_SET_READ_PARAM  = 8'hC0;
    localparam logic [7:0] OP_SET_BURST_WRAP  = 8'h77;
    localparam logic [7:0] OP_BURST_WRAP_READ = 8'h0C;
    localparam logic [7:0] OP_RESET_ARM       = 8'h66;
    localparam logic [7:0] OP_RESET_GO        = 8'h99;
    localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
    localparam logic [7:0] OP_SUSPEND         = 8'h75;
    localparam logic [7:0] OP_RESUME          = 8'h7A;

    // Frame field sizes, in bits.
    localparam logic [5:0] BYTE_BITS    = 6'h08;
    localparam logic [5:0] ADDR_BITS    = 6'h18;
    localparam logic [5:0] BITS_SERIAL  = 6'h01;
    localparam logic [5:0] BITS_FOURLN  = 6'h04;

    // Read parameter byte layout and decode.
    localparam int         DUMMY_LSB        = 4;
    localparam int         WRAP_LSB         = 0;
    localparam int         SERIAL_WRAP_LSB  = 4;
    localparam logic [1:0] DUMMY_SEL_RESET  = 2'h0;
    localparam logic [1:0] WRAP_SEL_RESET   = 2'h0;
    localparam logic [3:0] DUMMY_BASE       = 4'h2;
    localparam logic [3:0] SERIAL_FAST_DUMMY = 4'h8;
    localparam logic [7:0] WRAP_BASE_BYTES  = 8'h08;

    // Software reset recovery time.
    localparam int          T_RST_NS     = 30000;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          RST_CYCLES_I = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] RST_CYCLES   = 11'(RST_CYCLES_I);

    // APB register map.
    localparam int         APB_AW        = 8;
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_PARAM     = 8'h08;
    localparam int         CTRL_QE_BIT   = 0;
    localparam int         ST_MODE_BIT   = 0;
    localparam int         ST_WEL_BIT    = 1;
    localparam int         ST_SUSP_BIT   = 2;
    localparam int         ST_ARMED_BIT  = 3;
    localparam int         ST_BUSY_BIT   = 4;

    typedef enum logic [5:0] {
        PH_OPCODE = 6'h01,
        PH_ARG    = 6'h02,
        PH_ADDR   = 6'h04,
        PH_DUMMY  = 6'h08,
        PH_DATA   = 6'h10,
        PH_IGNORE = 6'h20
    } phase_t;

endpackage

/* File: verilog/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         rst_in,
    // Pins and synchronised copies
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_q[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule

/* File: verilog/flash_cmd_ctrl.sv */
// Function
// - Four-line mode accepts C0h setting dummy count and wrap length.
// - Serial mode rejects C0h; serial fast reads use a fixed dummy count.
// - In serial mode 77h sets wrap length from its serial wrap bits.
// - Mode switches keep write enable latch, suspend state and wrap length.
// - Power-up and software reset give 8-byte wrap and 2 dummy clocks.
// - Dummy field 00/01/10/11 gives 2/4/6/8 clocks, four-line reads only.
// - Wrap field 00/01/10/11 gives 8/16/32/64 bytes.
// - Opcode 0Ch reads like fast read, wrapping within aligned window; the code serves it in four-line mode only.
// - Only one mode at a time; only 38h enters four-line mode.
// - Power-up starts in serial mode.
// - 38h is ignored while the quad enable bit is 0.
// - FFh returns four-line mode to serial mode.
// - Accepted reset clears latches, suspend, read and wrap settings.
// - Reset needs 66h then 99h back to back; any other whole opcode disarms.
// - Reset takes about 30 us; no command accepted meanwhile.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module flash_cmd_ctrl
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    // Serial link pins from the host
    input  wire logic               cs_n_in,
    input  wire logic               sclk_in,
    input  wire logic [3:0]         io_in,
    output logic      [3:0]         io_out,
    output logic      [3:0]         io_oe_out,
    // Array read port
    input  wire logic [7:0]         array_data_in,
    output logic      [23:0]        rd_addr_out,
    // Mode and setting outputs
    output logic                    four_line_command_mode_out,
    output logic                    write_enable_latch_out,
    output logic                    suspend_flag_out,
    output logic      [3:0]         dummy_clocks_out,
    output logic                    reset_busy_out,
    // APB slave
    input  wire logic               psel_in,
    input  wire logic               penable_in,
    input  wire logic               pwrite_in,
    input  wire logic [APB_AW-1:0]  paddr_in,
    input  wire logic [31:0]        pwdata_in,
    output logic      [31:0]        prdata_out,
    output logic                    pready_out,
    output logic                    pslverr_out
);

    typedef struct packed {
        logic        mode;
        logic        write_enable_latch;
        logic        susp;
        logic        qe;
        logic [1:0]  dummy_sel;
        logic [1:0]  wrap_sel;
        logic        armed;
        logic [10:0] rst_cnt;
        logic        busy;
        logic        sclk_prev;
        logic        cs_prev;
        phase_t      phase;
        logic [5:0]  cnt;
        logic [7:0]  shreg;
        logic [7:0]  opcode;
        logic        op_ok;
        logic        arg_ok;
        logic [3:0]  dummy_left;
        logic        nib_lo;
        logic [23:0] addr;
        logic [3:0]  io;
        logic [3:0]  io_oe;
        logic [3:0]  dummy_clk;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } state_t;

    state_t     s_q;
    state_t     s_d;
    logic [5:0] pins_sync;

    pin_sync #(
        .W (6)
    ) u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .async_in   ({~cs_n_in, sclk_in, io_in}),
        .sync_out   (pins_sync)
    );

    // Chip select passes the synchroniser inverted so that its reset value reads as idle.
    wire logic       cs_n_s = ~pins_sync[5];
    wire logic       sclk_s = pins_sync[4];
    wire logic [3:0] io_s   = pins_sync[3:0];

    function automatic logic [3:0] dummy_decode(input logic [1:0] sel);
        dummy_decode = DUMMY_BASE + {1'b0, sel, 1'b0};
    endfunction

    function automatic logic [7:0] wrap_bytes(input logic [1:0] sel);
        wrap_bytes = WRAP_BASE_BYTES << sel;
    endfunction

    // Next read address, held inside the aligned wrap window.
    function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic [1:0] sel);
        logic [23:0] mask;
        mask = {16'h0000, wrap_bytes(sel) - 8'h01};
        wrap_next = (a & ~mask) | ((a + 24'h000001) & mask);
    endfunction

    logic       rise;
    logic       fall;
    logic       frame_end;
    logic [5:0] step;
    logic       byte_done;
    logic       apb_acc;

    always_comb begin
        s_d       = s_q;
        rise      = sclk_s && !s_q.sclk_prev;
        fall      = !sclk_s && s_q.sclk_prev;
        frame_end = cs_n_s && !s_q.cs_prev;
        step      = s_q.mode ? BITS_FOURLN : BITS_SERIAL;
        byte_done = (s_q.cnt + step) == BYTE_BITS;
        apb_acc   = psel_in && penable_in && !s_q.pready;

        s_d.sclk_prev = sclk_s;
        s_d.cs_prev   = cs_n_s;

        if (s_q.rst_cnt != 11'h000) begin
            // While the reset recovers, frames are dropped whole.
            s_d.rst_cnt = s_q.rst_cnt - 11'h001;
            s_d.phase   = PH_IGNORE;
            s_d.io_oe   = 4'h0;
        end else if (cs_n_s) begin
            s_d.phase = PH_OPCODE;
            s_d.cnt   = 6'h00;
            s_d.io_oe = 4'h0;
            s_d.op_ok  = 1'b0;
            s_d.arg_ok = 1'b0;
            // A frame cut before a whole opcode leaves the reset arming untouched.
            if (frame_end && s_q.op_ok) begin
                s_d.armed = (s_q.opcode == OP_RESET_ARM);
                unique case (s_q.opcode)
                    OP_ENTER_FOUR_LINE: begin
                        // Only the mode bit moves, so latch, suspend and wrap carry over.
                        if (!s_q.mode && s_q.qe) s_d.mode = 1'b1;
                    end
                    OP_EXIT_FOUR_LINE:  if (s_q.mode) s_d.mode = 1'b0;
                    OP_WRITE_ENABLE:    s_d.write_enable_latch  = 1'b1;
                    OP_WRITE_DISABLE:   s_d.write_enable_latch  = 1'b0;
                    OP_SUSPEND:         s_d.susp = 1'b1;
                    OP_RESUME:          s_d.susp = 1'b0;
                    OP_SET_READ_PARAM: begin
                        if (s_q.mode && s_q.arg_ok) begin
                            s_d.dummy_sel = s_q.shreg[DUMMY_LSB +: 2];
                            s_d.wrap_sel  = s_q.shreg[WRAP_LSB +: 2];
                        end
                    end
                    OP_SET_BURST_WRAP: begin
                        if (!s_q.mode && s_q.arg_ok) begin
                            s_d.wrap_sel = s_q.shreg[SERIAL_WRAP_LSB +: 2];
                        end
                    end
                    OP_RESET_GO: begin
                        if (s_q.armed) begin
                            // Power-on values; the mode change leaves nothing else.
                            s_d.mode      = 1'b0;
                            s_d.write_enable_latch       = 1'b0;
                            s_d.susp      = 1'b0;
                            s_d.dummy_sel = DUMMY_SEL_RESET;
                            s_d.wrap_sel  = WRAP_SEL_RESET;
                            s_d.rst_cnt   = RST_CYCLES;
                        end
                    end
                    default: ;
                endcase
            end
        end else begin
            unique case (s_q.phase)
                PH_OPCODE: begin
                    if (rise) begin
                        s_d.shreg = s_q.mode ? {s_q.shreg[3:0], io_s} : {s_q.shreg[6:0], io_s[0]};
                        s_d.cnt   = s_q.cnt + step;
                        if (byte_done) begin
                            s_d.opcode = s_d.shreg;
                            s_d.op_ok  = 1'b1;
                            s_d.cnt    = 6'h00;
                            if (s_d.shreg == OP_SET_READ_PARAM || s_d.shreg == OP_SET_BURST_WRAP)
                                s_d.phase = PH_ARG;
                            else if (s_d.shreg == OP_BURST_WRAP_READ && s_q.mode)
                                s_d.phase = PH_ADDR;
                            else
                                s_d.phase = PH_IGNORE;
                        end
                    end
                end
                PH_ARG: begin
                    if (rise) begin
                        s_d.shreg = s_q.mode ? {s_q.shreg[3:0], io_s} : {s_q.shreg[6:0], io_s[0]};
                        s_d.cnt   = s_q.cnt + step;
                        if (byte_done) begin
                            s_d.arg_ok = 1'b1;
                            s_d.phase  = PH_IGNORE;
                        end
                    end
                end
                PH_ADDR: begin
                    if (rise) begin
                        s_d.addr = {s_q.addr[19:0], io_s};
                        s_d.cnt  = s_q.cnt + BITS_FOURLN;
                        if (s_d.cnt == ADDR_BITS) begin
                            s_d.phase      = PH_DUMMY;
                            s_d.dummy_left = dummy_decode(s_q.dummy_sel);
                        end
                    end
                end
                PH_DUMMY: begin
                    if (rise) begin
                        s_d.dummy_left = s_q.dummy_left - 4'h1;
                        if (s_q.dummy_left == 4'h1) begin
                            s_d.phase  = PH_DATA;
                            s_d.nib_lo = 1'b0;
                        end
                    end
                end
                PH_DATA: begin
                    // Data changes on the falling edge so the host samples it on the rise.
                    if (fall) begin
                        s_d.io_oe  = 4'hF;
                        s_d.io     = s_q.nib_lo ? array_data_in[3:0] : array_data_in[7:4];
                        s_d.nib_lo = !s_q.nib_lo;
                        // The address moves after the low nibble, so each byte goes out once.
                        if (s_q.nib_lo) s_d.addr = wrap_next(s_q.addr, s_q.wrap_sel);
                    end
                end
                PH_IGNORE: ;
                default: s_d.phase = PH_IGNORE;
            endcase
        end

        // The serial fast reads keep a fixed count whatever the field holds.
        s_d.dummy_clk = s_d.mode ? dummy_decode(s_d.dummy_sel) : SERIAL_FAST_DUMMY;

        // Busy is kept in a flop so the pin carries no decode glitch.
        s_d.busy = (s_d.rst_cnt != 11'h000);

        // APB answers one cycle into the access phase.
        // Writes land on the first access edge; the wait state only carries the answer.
        s_d.pready  = apb_acc;
        s_d.pslverr = 1'b0;
        if (apb_acc) begin
            s_d.prdata = 32'h0000_0000;
            unique case (paddr_in)
                REG_CTRL: begin
                    if (pwrite_in) s_d.qe = pwdata_in[CTRL_QE_BIT];
                    s_d.prdata[CTRL_QE_BIT] = s_q.qe;
                end
                REG_STATUS: begin
                    s_d.prdata[ST_MODE_BIT]  = s_q.mode;
                    s_d.prdata[ST_WEL_BIT]   = s_q.write_enable_latch;
                    s_d.prdata[ST_SUSP_BIT]  = s_q.susp;
                    s_d.prdata[ST_ARMED_BIT] = s_q.armed;
                    s_d.prdata[ST_BUSY_BIT]  = (s_q.rst_cnt != 11'h000);
                end
                REG_PARAM: begin
                    s_d.prdata[DUMMY_LSB +: 2] = s_q.dummy_sel;
                    s_d.prdata[WRAP_LSB +: 2]  = s_q.wrap_sel;
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_q           <= '0;
            s_q.mode      <= 1'b0;
            s_q.dummy_sel <= DUMMY_SEL_RESET;
            s_q.wrap_sel  <= WRAP_SEL_RESET;
            s_q.dummy_clk <= SERIAL_FAST_DUMMY;
            s_q.phase     <= PH_OPCODE;
            s_q.cs_prev   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_out                     = s_q.io;
    assign io_oe_out                  = s_q.io_oe;
    assign rd_addr_out                = s_q.addr;
    assign four_line_command_mode_out = s_q.mode;
    assign write_enable_latch_out     = s_q.write_enable_latch;
    assign suspend_flag_out           = s_q.susp;
    assign dummy_clocks_out           = s_q.dummy_clk;
    assign reset_busy_out             = s_q.busy;
    assign prdata_out                 = s_q.prdata;
    assign pready_out                 = s_q.pready;
    assign pslverr_out                = s_q.pslverr;

endmodule

/* File: dv/flash_cmd_monitor.sv */
`timescale 1ns/10ps
module flash_cmd_monitor
    import flash_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    // Watched ports
    input  wire logic       cs_n_in,
    input  wire logic [3:0] io_oe_out,
    input  wire logic       four_line_command_mode_out,
    input  wire logic       write_enable_latch_out,
    input  wire logic       suspend_flag_out,
    input  wire logic [3:0] dummy_clocks_out,
    input  wire logic       reset_busy_out
);
    logic [11:0] busy_run_q;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // A repetition cannot span 1200 cycles, so the busy time is counted here.
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in)
            busy_run_q <= 12'h000;
        else if (reset_busy_out)
            busy_run_q <= busy_run_q + 12'h001;
        else
            busy_run_q <= 12'h000;
    end

    oe_idle_a: assert property (cs_n_in [*4] |-> io_oe_out == 4'h0)
        else $error("data lines driven outside a frame");
    oe_mode_a: assert property (io_oe_out != 4'h0 |-> four_line_command_mode_out)
        else $error("data lines driven in serial mode");
    dummy_fixed_a: assert property (!four_line_command_mode_out [*2] |-> dummy_clocks_out == 4'h8)
        else $error("serial dummy count not fixed");
    dummy_code_a: assert property (four_line_command_mode_out [*2] |->
        dummy_clocks_out inside {4'h2, 4'h4, 4'h6, 4'h8})
        else $error("dummy count outside decode");
    mode_frame_a: assert property ($changed(four_line_command_mode_out) |-> $past(cs_n_in, 2))
        else $error("mode changed inside a frame");
    mode_keep_a: assert property ($changed(four_line_command_mode_out) && !reset_busy_out |->
        $stable(write_enable_latch_out) && $stable(suspend_flag_out))
        else $error("mode switch lost latch or suspend");
    reset_clear_a: assert property ($rose(reset_busy_out) |-> !write_enable_latch_out &&
        !suspend_flag_out && !four_line_command_mode_out)
        else $error("software reset left state behind");
    busy_freeze_a: assert property (reset_busy_out && $past(reset_busy_out) |->
        $stable(write_enable_latch_out) && $stable(four_line_command_mode_out))
        else $error("command taken during reset recovery");
    busy_len_a: assert property ($fell(reset_busy_out) |->
        busy_run_q >= 12'h4AF && busy_run_q <= 12'h4B1)
        else $error("reset recovery length wrong");
endmodule

bind flash_cmd_ctrl flash_cmd_monitor u_mon (
    .clk_sys_in                 (clk_sys_in),
    .rst_in                     (rst_in),
    .cs_n_in                    (cs_n_in),
    .io_oe_out                  (io_oe_out),
    .four_line_command_mode_out (four_line_command_mode_out),
    .write_enable_latch_out     (write_enable_latch_out),
    .suspend_flag_out           (suspend_flag_out),
    .dummy_clocks_out           (dummy_clocks_out),
    .reset_busy_out             (reset_busy_out)
);

/* File: dv/flash_host_model.sv */
`timescale 1ns/10ps
module flash_host_model (
    // Clock
    input  wire logic       clk_sys_in,
    // Link pins towards the device
    output logic            cs_n_out,
    output logic            sclk_out,
    output logic [3:0]      io_out,
    input  wire logic [3:0] dev_io_in
);
    logic [7:0] rd_q [$];

    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        io_out   = 4'h0;
    end

    // The low phase is long so the device's synchronised output settles first.
    task automatic tick(input logic [3:0] v, output logic [3:0] got);
        @(posedge clk_sys_in);
        io_out   <= v;
        sclk_out <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        got = dev_io_in;
        sclk_out <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
    endtask

    // Clock stands low between frames; released data lines toggle.
    task automatic frame(input logic four, input logic [7:0] b [$], input int dmy, input int nrd);
        logic [3:0] got;
        logic [3:0] hi;
        int         w;
        w = four ? 4 : 1;
        rd_q.delete();
        @(posedge clk_sys_in);
        cs_n_out <= 1'b0;
        foreach (b[i])
            for (int k = 8 - w; k >= 0; k -= w)
                tick(four ? 4'(b[i] >> k) : {3'h0, b[i][k]}, got);
        repeat (dmy) tick(~io_out, got);
        repeat (nrd) begin
            tick(~io_out, hi);
            tick(~io_out, got);
            rd_q.push_back({hi, got});
        end
        @(posedge clk_sys_in);
        sclk_out <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        cs_n_out <= 1'b1;
        io_out   <= ~io_out;
        repeat (12) @(posedge clk_sys_in);
    endtask
endmodule

/* File: dv/quad_mode_read_param_reset_ctrl_test.sv */
`timescale 1ns/10ps
module quad_mode_read_param_reset_ctrl_test;
    import flash_cmd_pkg::*;
    logic        clk_sys_in, rst_in, cs_n, sclk, mode, write_enable_latch, susp, busy, four, err;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [3:0]  host_io, io_out, io_oe, dummy;
    logic [7:0]  paddr, ea;
    logic [23:0] rd_addr;
    logic [31:0] pwdata, prdata, rd;
    int          failures, compares, n;
    int          cycles = 0;

    flash_host_model host (.clk_sys_in(clk_sys_in), .cs_n_out(cs_n), .sclk_out(sclk),
        .io_out(host_io), .dev_io_in(io_out));
    flash_cmd_ctrl dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .io_in(host_io), .io_out(io_out), .io_oe_out(io_oe),
        .array_data_in(rd_addr[7:0] ^ 8'h5A), .rd_addr_out(rd_addr),
        .four_line_command_mode_out(mode), .write_enable_latch_out(write_enable_latch),
        .suspend_flag_out(susp), .dummy_clocks_out(dummy), .reset_busy_out(busy),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));

    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        // Only the bench timeout ends this wait.
        do begin
            @(posedge clk_sys_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic st(input logic [4:0] e);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status", rd, {27'h0, e});
    endtask

    task automatic prm(input logic [31:0] e);
        apb(1'b0, REG_PARAM, 32'h0);
        chk("param", rd, e);
    endtask

    task automatic cmd(input logic [7:0] b [$]);
        host.frame(four, b, 0, 0);
    endtask

    initial begin
        rst_in = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {failures, compares, four} = '0;
        repeat (4) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        st(5'h00);
        prm(32'h0);
        cmd('{OP_ENTER_FOUR_LINE});
        st(5'h00);
        cmd('{OP_EXIT_FOUR_LINE});
        st(5'h00);
        cmd('{OP_SET_READ_PARAM, 8'h31});
        prm(32'h0);
        cmd('{OP_SET_BURST_WRAP, 8'h20});
        prm(32'h2);
        cmd('{OP_WRITE_ENABLE});
        cmd('{OP_SUSPEND});
        apb(1'b1, REG_CTRL, 32'h1);
        cmd('{OP_ENTER_FOUR_LINE});
        four = 1'b1;
        st(5'h07);
        prm(32'h2);
        chk("dummy", {28'h0, dummy}, 32'h2);
        chk("mode pins", {29'h0, susp, write_enable_latch, mode}, 32'h7);
        cmd('{OP_SET_BURST_WRAP, 8'h10});
        prm(32'h2);
        for (int k = 0; k < 4; k++) begin
            cmd('{OP_SET_READ_PARAM, 8'(k * 17)});
            prm(32'(k * 17));
            chk("dummy", {28'h0, dummy}, 32'(2 + 2 * k));
        end
        // Each read starts two bytes before the window end so it must wrap.
        for (int k = 0; k < 2; k++) begin
            cmd('{OP_SET_READ_PARAM, k ? 8'h32 : 8'h10});
            host.frame(1'b1, '{OP_BURST_WRAP_READ, 8'h00, 8'h01, k ? 8'h3E : 8'h06},
                k ? 8 : 4, 4);
            for (int i = 0; i < 4; i++) begin
                n = k ? 31 : 7;
                ea = ((k ? 8'h3E : 8'h06) & ~8'(n)) | ((8'(i) + (k ? 8'h3E : 8'h06)) & 8'(n));
                chk("wrap data", {24'h0, host.rd_q[i]}, {24'h0, ea ^ 8'h5A});
            end
        end
        cmd('{OP_EXIT_FOUR_LINE});
        four = 1'b0;
        st(5'h06);
        apb(1'b0, REG_PARAM, 32'h0);
        chk("wrap kept", {30'h0, rd[1:0]}, 32'h2);
        cmd('{OP_RESET_ARM});
        st(5'h0E);
        cmd('{OP_WRITE_DISABLE});
        cmd('{OP_RESET_GO});
        st(5'h04);
        cmd('{OP_RESET_ARM});
        cmd('{OP_RESET_GO});
        st(5'h10);
        prm(32'h0);
        cmd('{OP_WRITE_ENABLE});
        st(5'h10);
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk_sys_in);
            n++;
        end
        chk("busy end", {31'h0, busy}, 32'h0);
        cmd('{OP_WRITE_ENABLE});
        st(5'h02);
        cmd('{OP_SUSPEND});
        st(5'h06);
        cmd('{OP_RESUME});
        st(5'h02);
        results();
    end
endmodule
